// [hdl/i2cfs_cfg.svh]
// i2cfs_cfg.svh - register map, field positions and reset values of the
// I2C FIFO status, slave transmit data and slave address block.
// Assumes a 32-bit APB master with byte addresses and one word per register.
// Function
// - A write-only 8-bit slave transmit data register, reset to zero, hands each written byte to the slave transmit path.
// - Four independent read/write 8-bit slave address registers, reset to zero, each give an address the slave answers.
// - Writing one to bit 9 of the FIFO status register discards everything in the master transmit FIFO.
// - Writing one to bit 8 of the FIFO status register discards everything in the slave transmit FIFO.
// - Bits 7:6 show the master receive FIFO as empty, byte just written, one byte held or full.
// - Bits 5:4 show the master transmit FIFO with the same four codes.
// - Bits 3:2 show the slave receive FIFO with the same four codes.
// - Bits 1:0 show the slave transmit FIFO with the same four codes.
// - The FIFO status register is 16 bits, resets to zero, reads zero in 15:10 and is valid in master and slave modes.
// - The slave flags underflow when a master asks for read data while the slave transmit FIFO is empty.
`ifndef I2CFS_CFG_SVH
`define I2CFS_CFG_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define I2CFS_ADDR_STX      32'hffff0934
`define I2CFS_ADDR_ID0      32'hffff093c
`define I2CFS_ADDR_ID1      32'hffff0940
`define I2CFS_ADDR_ID2      32'hffff0944
`define I2CFS_ADDR_ID3      32'hffff0948
`define I2CFS_ADDR_FSTA     32'hffff094c
`define I2CFS_ADDR_IRQ_STAT 32'hffff0950
`define I2CFS_ADDR_IRQ_MASK 32'hffff0954

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define I2CFS_BIT_MTX_FLUSH 9
`define I2CFS_BIT_STX_FLUSH 8
`define I2CFS_RST_BYTE      8'h00
`define I2CFS_RST_FSTA      16'h0000
`define I2CFS_IRQ_W         3
`define I2CFS_IRQ_UFL       0
`define I2CFS_IRQ_MRX_FULL  1
`define I2CFS_IRQ_SRX_FULL  2
`define I2CFS_RST_IRQ       3'h0
`define I2CFS_FIFO_DEPTH    2

`endif

// [hdl/i2cfs_pkg.sv]
// i2cfs_pkg.sv - types shared by the FIFO status block and its helpers.
// Assumes the constants of i2cfs_cfg.svh for every number.
package i2cfs_pkg;

  // Fill state codes reported per FIFO
  typedef enum logic [1:0]
  {
    FILL_EMPTY   = 2'h0,
    FILL_WRITTEN = 2'h1,
    FILL_ONE     = 2'h2,
    FILL_FULL    = 2'h3
  } i2cfs_fill_t;

  // One byte with its valid flag
  typedef struct packed
  {
    logic       valid;
    logic [7:0] data;
  } i2cfs_byte_t;

  // APB answer sequencer
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'h1,
    ST_DONE = 2'h2
  } i2cfs_apb_st_t;

endpackage

// [hdl/i2cfs_fifo2.sv]
// i2cfs_fifo2.sv - two-byte FIFO that reports its fill state code.
// Assumes push and pop are single-cycle strobes synchronous to mclk_in.
`timescale 1ns/100ps
`include "i2cfs_cfg.svh"
module i2cfs_fifo2
(
  // Clock and reset
  input  wire logic                   mclk_in,
  input  wire logic                   arst_n_in,
  // Filling side
  input  wire i2cfs_pkg::i2cfs_byte_t push_in,
  input  wire logic                   flush_in,
  // Draining side
  input  wire logic                   pop_in,
  output i2cfs_pkg::i2cfs_byte_t      head_out,
  output i2cfs_pkg::i2cfs_fill_t      fill_out
);
  import i2cfs_pkg::*;

  logic [7:0]  mem_r [0:`I2CFS_FIFO_DEPTH-1];
  logic [1:0]  cnt_r;
  logic [1:0]  cnt_nxt;
  logic        push_ok;
  logic        pop_ok;
  logic        wr_idx;
  logic        valid_r;
  i2cfs_fill_t fill_r;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);

  // A full FIFO refuses a push; the producer must watch the fill code
  assign pop_ok  = pop_in && (cnt_r != 2'd0);
  assign push_ok = push_in.valid && (cnt_r != 2'(`I2CFS_FIFO_DEPTH)) && !flush_in;
  assign wr_idx  = cnt_r[0] ^ pop_ok;

  // flush clears count
  // Count, flush wins over any push or pop
  always_comb
  begin
    if (flush_in)
      cnt_nxt = 2'd0;
    else
      cnt_nxt = cnt_r + {1'b0, push_ok} - {1'b0, pop_ok};
  end

  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      cnt_r <= 2'd0;
    else
      cnt_r <= cnt_nxt;
  end

  // Shifting storage keeps the head in a flop of its own
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      mem_r[0] <= `I2CFS_RST_BYTE;
      mem_r[1] <= `I2CFS_RST_BYTE;
    end
    else
    begin
      if (pop_ok)
        mem_r[0] <= mem_r[1];
      if (push_ok)
        mem_r[wr_idx] <= push_in.data;
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      fill_r  <= FILL_EMPTY;
      valid_r <= 1'b0;
    end
    else
    begin
      valid_r <= (cnt_nxt != 2'd0);
      unique case (cnt_nxt)
        2'd0:    fill_r <= FILL_EMPTY;
        2'd1:    fill_r <= push_ok ? FILL_WRITTEN : FILL_ONE;
        default: fill_r <= FILL_FULL;
      endcase
    end
  end

  assign head_out = '{valid: valid_r, data: mem_r[0]};
  assign fill_out = fill_r;

  sequence s_push_to_empty;
    push_ok && !pop_ok && (cnt_r == 2'd0);
  endsequence
  a_fill_written: assert property (s_push_to_empty |=> fill_r == FILL_WRITTEN)
    else $error("push into empty FIFO not shown as just written");
  a_fill_full_code: assert property ((cnt_r == 2'd2) |-> fill_r == FILL_FULL)
    else $error("full FIFO not shown as full");
  a_flush_empties: assert property (flush_in |=> (fill_r == FILL_EMPTY) && !valid_r)
    else $error("flush did not empty the FIFO");
endmodule

// [hdl/i2cfs_irq.sv]
// i2cfs_irq.sv - sticky event status with read-clear and a masked level.
// Assumes clear bits are exactly those software has already read.
`timescale 1ns/100ps
`include "i2cfs_cfg.svh"
module i2cfs_irq
(
  // Clock and reset
  input  wire logic                     mclk_in,
  input  wire logic                     arst_n_in,
  // Events and software side
  input  wire logic [`I2CFS_IRQ_W-1:0]  event_in,
  input  wire logic [`I2CFS_IRQ_W-1:0]  clear_in,
  input  wire logic [`I2CFS_IRQ_W-1:0]  mask_in,
  // Results
  output logic      [`I2CFS_IRQ_W-1:0]  status_out,
  output logic                          irq_out
);
  import i2cfs_pkg::*;

  logic [`I2CFS_IRQ_W-1:0] stat_r;
  logic [`I2CFS_IRQ_W-1:0] stat_nxt;
  logic                    irq_r;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);

  // A fresh event beats a clear in the same cycle
  assign stat_nxt = (stat_r & ~clear_in) | event_in;

  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      stat_r <= `I2CFS_RST_IRQ;
      irq_r  <= 1'b0;
    end
    else
    begin
      stat_r <= stat_nxt;
      irq_r  <= |(stat_nxt & mask_in);
    end
  end

  assign status_out = stat_r;
  assign irq_out    = irq_r;

  a_irq_follows: assert property (|(event_in & mask_in) |=> irq_r && |stat_r)
    else $error("unmasked event did not raise the interrupt");
endmodule

// [hdl/i2cfs_top.sv]
// i2cfs_top.sv - APB register block holding the slave transmit data
// register, four slave addresses, the FIFO status and flush register,
// an event status and mask pair, and the four two-byte FIFOs.
// Assumes the protocol engine drives pushes, pops and read requests
// as one-cycle strobes synchronous to mclk_in.
//
// Design decision made here: register access over APB.
`timescale 1ns/100ps
`include "i2cfs_cfg.svh"
module i2cfs_top
(
  // Clock and reset
  input  wire logic                   mclk_in,
  input  wire logic                   arst_n_in,
  // APB slave
  input  wire logic [31:0]            paddr_in,
  input  wire logic                   psel_in,
  input  wire logic                   penable_in,
  input  wire logic                   pwrite_in,
  input  wire logic [31:0]            pwdata_in,
  input  wire logic [3:0]             pstrb_in,
  output logic      [31:0]            prdata_out,
  output logic                        pready_out,
  output logic                        pslverr_out,
  // Master side of the engine
  input  wire i2cfs_pkg::i2cfs_byte_t mtx_push_in,
  input  wire logic                   mtx_pop_in,
  output i2cfs_pkg::i2cfs_byte_t      mtx_head_out,
  input  wire i2cfs_pkg::i2cfs_byte_t mrx_push_in,
  input  wire logic                   mrx_pop_in,
  output i2cfs_pkg::i2cfs_byte_t      mrx_head_out,
  // Slave side of the engine
  input  wire logic                   stx_req_in,
  output i2cfs_pkg::i2cfs_byte_t      stx_head_out,
  input  wire i2cfs_pkg::i2cfs_byte_t srx_push_in,
  input  wire logic                   srx_pop_in,
  output i2cfs_pkg::i2cfs_byte_t      srx_head_out,
  output logic      [3:0][7:0]        slave_address_out,
  output logic                        slave_tx_underflow_out,
  // Interrupt
  output logic                        irq_out
);
  import i2cfs_pkg::*;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------

  // One-hot select of the four slave address registers
  function automatic logic [3:0] id_sel(input logic [31:0] a);
    logic [3:0] s;
    s    = 4'h0;
    s[0] = (a == `I2CFS_ADDR_ID0);
    s[1] = (a == `I2CFS_ADDR_ID1);
    s[2] = (a == `I2CFS_ADDR_ID2);
    s[3] = (a == `I2CFS_ADDR_ID3);
    return s;
  endfunction

  // True for any address this block answers
  function automatic logic is_mapped(input logic [31:0] a);
    return (|id_sel(a)) ||
           (a == `I2CFS_ADDR_STX) ||
           (a == `I2CFS_ADDR_FSTA) ||
           (a == `I2CFS_ADDR_IRQ_STAT) ||
           (a == `I2CFS_ADDR_IRQ_MASK);
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  i2cfs_apb_st_t           st_r;
  logic                    pready_r;
  logic                    pslverr_r;
  logic [31:0]             prdata_r;
  logic [31:0]             rdata;
  logic                    xfer_done;
  logic                    wr_done;
  logic                    rd_done;
  logic [3:0]              id_hit;
  logic [3:0][7:0]         slave_address_r;
  logic [7:0]              stx_data_r;
  logic                    stx_push_r;
  logic                    mtx_flush;
  logic                    stx_flush;
  logic                    stx_pop;
  logic                    ufl_r;
  logic [`I2CFS_IRQ_W-1:0] mask_r;
  logic [`I2CFS_IRQ_W-1:0] irq_stat;
  logic [`I2CFS_IRQ_W-1:0] irq_evt;
  logic [`I2CFS_IRQ_W-1:0] irq_clr;
  logic                    mrx_full_q;
  logic                    srx_full_q;
  i2cfs_byte_t             stx_push;
  i2cfs_byte_t             stx_head;
  i2cfs_fill_t             mrx_fill;
  i2cfs_fill_t             mtx_fill;
  i2cfs_fill_t             srx_fill;
  i2cfs_fill_t             stx_fill;
  logic [15:0]             fsta_view;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);

  // ----------------------------------------------------------------
  // APB sequencer
  // ----------------------------------------------------------------

  // The edge where pready is sampled high is the only one that commits
  assign xfer_done = (st_r == ST_DONE) && psel_in && penable_in;
  assign wr_done   = xfer_done && pwrite_in;
  assign rd_done   = xfer_done && !pwrite_in;
  assign id_hit    = id_sel(paddr_in);

  // One wait cycle lets read data come from a flop
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      st_r     <= ST_IDLE;
      pready_r <= 1'b0;
    end
    else
    begin
      unique case (st_r)
        ST_IDLE:
        begin
          if (psel_in && penable_in)
          begin
            st_r     <= ST_DONE;
            pready_r <= 1'b1;
          end
        end
        ST_DONE:
        begin
          st_r     <= ST_IDLE;
          pready_r <= 1'b0;
        end
      endcase
    end
  end

  // Read data mux, reserved bits read as zero
  always_comb
  begin
    rdata = 32'h0;
    if (|id_hit)
      rdata[7:0] = slave_address_r[0] & {8{id_hit[0]}} |
                   slave_address_r[1] & {8{id_hit[1]}} |
                   slave_address_r[2] & {8{id_hit[2]}} |
                   slave_address_r[3] & {8{id_hit[3]}};
    else if (paddr_in == `I2CFS_ADDR_FSTA)
      rdata[15:0] = fsta_view;
    else if (paddr_in == `I2CFS_ADDR_IRQ_STAT)
      rdata[`I2CFS_IRQ_W-1:0] = irq_stat;
    else if (paddr_in == `I2CFS_ADDR_IRQ_MASK)
      rdata[`I2CFS_IRQ_W-1:0] = mask_r;
  end

  // Answer registers, captured at the end of the access wait, on the edge that raises pready
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      prdata_r  <= 32'h0;
      pslverr_r <= 1'b0;
    end
    else if ((st_r == ST_IDLE) && psel_in && penable_in)
    begin
      prdata_r  <= pwrite_in ? 32'h0 : rdata;
      pslverr_r <= !is_mapped(paddr_in);
    end
    else if (st_r == ST_DONE)
    begin
      prdata_r  <= 32'h0;
      pslverr_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Slave address registers
  // ----------------------------------------------------------------

  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      slave_address_r <= {4{`I2CFS_RST_BYTE}};
    else if (wr_done && pstrb_in[0])
    begin
      for (int i = 0; i < 4; i++)
        if (id_hit[i])
          slave_address_r[i] <= pwdata_in[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Slave transmit data path
  // ----------------------------------------------------------------

  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      stx_data_r <= `I2CFS_RST_BYTE;
      stx_push_r <= 1'b0;
    end
    else
    begin
      stx_push_r <= wr_done && pstrb_in[0] && (paddr_in == `I2CFS_ADDR_STX);
      if (wr_done && pstrb_in[0] && (paddr_in == `I2CFS_ADDR_STX))
        stx_data_r <= pwdata_in[7:0];
    end
  end

  assign stx_push = '{valid: stx_push_r, data: stx_data_r};

  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      ufl_r <= 1'b0;
    else
      ufl_r <= stx_req_in && !stx_head.valid;
  end

  assign stx_pop = stx_req_in && stx_head.valid;

  // ----------------------------------------------------------------
  // Flush commands and FIFO status view
  // ----------------------------------------------------------------

  // master transmit flush, a pulse that stores nothing
  assign mtx_flush = wr_done && pstrb_in[1] && (paddr_in == `I2CFS_ADDR_FSTA) &&
                     pwdata_in[`I2CFS_BIT_MTX_FLUSH];
  assign stx_flush = wr_done && pstrb_in[1] && (paddr_in == `I2CFS_ADDR_FSTA) &&
                     pwdata_in[`I2CFS_BIT_STX_FLUSH];

  // packed status view, flush bits always read zero
  assign fsta_view = {6'h00, 2'h0, mrx_fill, mtx_fill, srx_fill, stx_fill};

  i2cfs_fifo2 u_stx_fifo
  (
    .mclk_in   (mclk_in),
    .arst_n_in (arst_n_in),
    .push_in   (stx_push),
    .flush_in  (stx_flush),
    .pop_in    (stx_pop),
    .head_out  (stx_head),
    .fill_out  (stx_fill)
  );

  i2cfs_fifo2 u_mtx_fifo
  (
    .mclk_in   (mclk_in),
    .arst_n_in (arst_n_in),
    .push_in   (mtx_push_in),
    .flush_in  (mtx_flush),
    .pop_in    (mtx_pop_in),
    .head_out  (mtx_head_out),
    .fill_out  (mtx_fill)
  );

  i2cfs_fifo2 u_mrx_fifo
  (
    .mclk_in   (mclk_in),
    .arst_n_in (arst_n_in),
    .push_in   (mrx_push_in),
    .flush_in  (1'b0),
    .pop_in    (mrx_pop_in),
    .head_out  (mrx_head_out),
    .fill_out  (mrx_fill)
  );

  i2cfs_fifo2 u_srx_fifo
  (
    .mclk_in   (mclk_in),
    .arst_n_in (arst_n_in),
    .push_in   (srx_push_in),
    .flush_in  (1'b0),
    .pop_in    (srx_pop_in),
    .head_out  (srx_head_out),
    .fill_out  (srx_fill)
  );

  // ----------------------------------------------------------------
  // Interrupt events, mask and status
  // ----------------------------------------------------------------

  // Receive FIFOs raise an event only on the step into full
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      mrx_full_q <= 1'b0;
      srx_full_q <= 1'b0;
    end
    else
    begin
      mrx_full_q <= (mrx_fill == FILL_FULL);
      srx_full_q <= (srx_fill == FILL_FULL);
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      mask_r <= `I2CFS_RST_IRQ;
    else if (wr_done && pstrb_in[0] && (paddr_in == `I2CFS_ADDR_IRQ_MASK))
      mask_r <= pwdata_in[`I2CFS_IRQ_W-1:0];
  end

  assign irq_evt[`I2CFS_IRQ_UFL]      = ufl_r;
  assign irq_evt[`I2CFS_IRQ_MRX_FULL] = (mrx_fill == FILL_FULL) && !mrx_full_q;
  assign irq_evt[`I2CFS_IRQ_SRX_FULL] = (srx_fill == FILL_FULL) && !srx_full_q;

  // Only bits already returned to software are cleared, so nothing is lost
  assign irq_clr = (rd_done && (paddr_in == `I2CFS_ADDR_IRQ_STAT)) ?
                   prdata_r[`I2CFS_IRQ_W-1:0] : `I2CFS_RST_IRQ;

  i2cfs_irq u_irq
  (
    .mclk_in    (mclk_in),
    .arst_n_in  (arst_n_in),
    .event_in   (irq_evt),
    .clear_in   (irq_clr),
    .mask_in    (mask_r),
    .status_out (irq_stat),
    .irq_out    (irq_out)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata_out             = prdata_r;
  assign pready_out             = pready_r;
  assign pslverr_out            = pslverr_r;
  assign stx_head_out           = stx_head;
  assign slave_address_out      = slave_address_r;
  assign slave_tx_underflow_out = ufl_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_access_start;
    (st_r == ST_IDLE) && psel_in && penable_in;
  endsequence
  sequence s_stx_write;
    wr_done && pstrb_in[0] && (paddr_in == `I2CFS_ADDR_STX);
  endsequence
  sequence s_fsta_read;
    rd_done && (paddr_in == `I2CFS_ADDR_FSTA);
  endsequence

  a_apb_answer: assert property (s_access_start |=> pready_r ##1 !pready_r)
    else $error("APB answer not given in the second access cycle");
  a_stx_byte_push: assert property (s_stx_write |=> stx_push_r && (stx_data_r == $past(pwdata_in[7:0])))
    else $error("slave transmit write did not push its byte");
  a_id_write_holds: assert property (wr_done && pstrb_in[0] && id_hit[2] |=>
                                     slave_address_r[2] == $past(pwdata_in[7:0]))
    else $error("slave address write not stored");
  a_mtx_flush_empty: assert property (mtx_flush |=> mtx_fill == FILL_EMPTY)
    else $error("master transmit flush did not empty the FIFO");
  a_stx_flush_empty: assert property (stx_flush |=> stx_fill == FILL_EMPTY ##1 !stx_head.valid)
    else $error("slave transmit flush did not empty the FIFO");
  a_fsta_reserved_zero: assert property (s_fsta_read |-> prdata_r[31:10] == 22'h0)
    else $error("reserved FIFO status bits read nonzero");
  a_flush_bits_clear: assert property (s_fsta_read |-> prdata_r[9:8] == 2'h0)
    else $error("flush request bits read back set");
  a_underflow_flag: assert property (stx_req_in && !stx_head.valid |=> ufl_r ##1 irq_stat[0])
    else $error("empty read request did not flag underflow");
  a_fill_in_view: assert property (s_access_start ##0 (paddr_in == `I2CFS_ADDR_FSTA) && !pwrite_in
                                   |=> prdata_r[7:0] == $past(fsta_view[7:0]))
    else $error("FIFO fill codes not returned on read");
endmodule

// [sim/i2cfs_engine_model.sv]
// i2cfs_engine_model.sv - protocol engine stand-in: turns bench commands into FIFO strobes.
// Assumes commands are held for one cycle; each strobe lasts exactly one cycle.
`timescale 1ns/100ps
module i2cfs_engine_model
(
  // Clock, reset and bench command
  input  wire logic                   mclk_in,
  input  wire logic                   arst_n_in,
  input  wire logic [2:0]             op_in,
  input  wire logic [7:0]             byte_in,
  // Strobes to the block
  output i2cfs_pkg::i2cfs_byte_t      mtx_push_out,
  output logic                        mtx_pop_out,
  output logic                        mrx_pop_out,
  output i2cfs_pkg::i2cfs_byte_t      mrx_push_out,
  output i2cfs_pkg::i2cfs_byte_t      srx_push_out,
  output logic                        srx_pop_out,
  output logic                        stx_req_out
);
  import i2cfs_pkg::*;
  // Idle data is the inverse so a stale byte never looks valid
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      mtx_push_out <= '0;
      mrx_push_out <= '0;
      srx_push_out <= '0;
      srx_pop_out  <= 1'b0;
      stx_req_out  <= 1'b0;
      mtx_pop_out  <= 1'b0;
      mrx_pop_out  <= 1'b0;
    end
    else
    begin
      mtx_push_out <= {op_in == 3'h1, (op_in == 3'h1) ? byte_in : ~byte_in};
      mrx_push_out <= {op_in == 3'h2, (op_in == 3'h2) ? byte_in : ~byte_in};
      srx_push_out <= {op_in == 3'h3, (op_in == 3'h3) ? byte_in : ~byte_in};
      stx_req_out  <= (op_in == 3'h4);
      srx_pop_out  <= (op_in == 3'h7);
      mtx_pop_out  <= (op_in == 3'h5);
      mrx_pop_out  <= (op_in == 3'h6);
    end
  end
endmodule

// [sim/testbench.sv]
// testbench.sv - register and FIFO state checks of the FIFO status block.
// Assumes the engine model feeds pushes and read requests.
`timescale 1ns/100ps
`include "i2cfs_cfg.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module testbench;
  import i2cfs_pkg::*;
  logic                  clk, rst_n, psel, pen, pwr, err, sreq, spop, mpop, rpop;
  logic       [31:0]     addr, wdat, rdat, prd;
  logic       [2:0]      op;
  logic       [7:0]      ob;
  logic                  rdy, slverr, ufl, irq;
  logic       [3:0][7:0] ids;
  i2cfs_byte_t           mtxp, mrxp, srxp, mtxh, stxh, mrxh, srxh;
  int                    n_fail, num_checks;

  i2cfs_top dut (.mclk_in(clk), .arst_n_in(rst_n), .paddr_in(addr), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .pwdata_in(wdat), .pstrb_in(4'hf), .prdata_out(prd),
    .pready_out(rdy), .pslverr_out(slverr), .mtx_push_in(mtxp), .mtx_pop_in(mpop),
    .mtx_head_out(mtxh), .mrx_push_in(mrxp), .mrx_pop_in(rpop), .mrx_head_out(mrxh),
    .stx_req_in(sreq), .stx_head_out(stxh), .srx_push_in(srxp), .srx_pop_in(spop),
    .srx_head_out(srxh), .slave_address_out(ids), .slave_tx_underflow_out(ufl), .irq_out(irq));
  i2cfs_engine_model eng_m (.mclk_in(clk), .arst_n_in(rst_n), .op_in(op), .byte_in(ob),
    .mtx_push_out(mtxp), .mtx_pop_out(mpop), .mrx_pop_out(rpop), .mrx_push_out(mrxp),
    .srx_push_out(srxp), .srx_pop_out(spop), .stx_req_out(sreq));

  // APB transfer: hold the request until pready is sampled high
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pwr <= w; addr <= a; wdat <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk iff rdy === 1'b1);
    rdat = prd;
    err  = slverr;
    psel <= 1'b0; pen <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rdat)
  endtask
  task automatic eng(input logic [2:0] o, input logic [7:0] b);
    @(posedge clk);
    op <= o; ob <= b;
    @(posedge clk);
    op <= 3'h0;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Watchdog, well past the two hundred or so cycles the tests need
  initial
  begin
    repeat (5000) @(posedge clk);
    n_fail++;
    final_report();
  end
  // Tests
  initial
  begin
    rst_n = 0; psel = 0; pen = 0; pwr = 0; addr = 0; wdat = 0; op = 0; ob = 0;
    n_fail = 0; num_checks = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(`I2CFS_ADDR_STX, 32'h0, "stx_read");
    rd(`I2CFS_ADDR_FSTA, 32'h0, "fsta_reset");
    rd(`I2CFS_ADDR_IRQ_MASK, 32'h0, "mask_reset");
    for (int i = 0; i < 4; i++)
    begin
      rd(`I2CFS_ADDR_ID0 + 4 * i, 32'h0, "id_reset");
      apb(1'b1, `I2CFS_ADDR_ID0 + 4 * i, 32'hffffff00 | (32'h11 * (i + 1)));
    end
    for (int i = 0; i < 4; i++)
    begin
      rd(`I2CFS_ADDR_ID0 + 4 * i, 32'h11 * (i + 1), "id_value");
      `CHK("id_pin", 8'(8'h11 * (i + 1)), ids[i])
    end
    $display("test registers done");
    // Two bytes fill the slave tx FIFO; a request drains one
    apb(1'b1, `I2CFS_ADDR_STX, 32'h5a);
    apb(1'b1, `I2CFS_ADDR_STX, 32'ha5);
    repeat (3) @(posedge clk);
    rd(`I2CFS_ADDR_FSTA, 32'h3, "stx_full");
    `CHK("stx_head", 9'h15a, stxh)
    eng(3'h4, 8'h0);
    repeat (3) @(posedge clk);
    rd(`I2CFS_ADDR_FSTA, 32'h2, "stx_one");
    `CHK("stx_head2", 9'h1a5, stxh)
    apb(1'b1, `I2CFS_ADDR_FSTA, 32'h100);
    rd(`I2CFS_ADDR_FSTA, 32'h0, "stx_flushed");
    $display("test slave tx done");
    // Request on an empty FIFO raises underflow and the interrupt
    apb(1'b1, `I2CFS_ADDR_IRQ_MASK, 32'h7);
    eng(3'h4, 8'h0);
    @(posedge clk);
    @(negedge clk);
    `CHK("underflow", 1'b1, ufl)
    repeat (3) @(posedge clk);
    `CHK("irq_set", 1'b1, irq)
    rd(`I2CFS_ADDR_IRQ_STAT, 32'h1, "stat_ufl");
    repeat (3) @(posedge clk);
    `CHK("irq_clr", 1'b0, irq)
    $display("test underflow done");
    // Fill master FIFOs, one slave rx byte, then flush master tx only
    eng(3'h1, 8'h11);
    eng(3'h1, 8'h22);
    eng(3'h2, 8'h33);
    eng(3'h2, 8'h44);
    eng(3'h3, 8'h55);
    repeat (3) @(posedge clk);
    rd(`I2CFS_ADDR_FSTA, 32'hf8, "fill_mix");
    `CHK("mrx_head", 9'h133, mrxh)
    `CHK("srx_head", 9'h155, srxh)
    rd(`I2CFS_ADDR_IRQ_STAT, 32'h2, "stat_mrx");
    eng(3'h5, 8'h0);
    repeat (3) @(posedge clk);
    rd(`I2CFS_ADDR_FSTA, 32'he8, "mtx_popped");
    `CHK("mtx_head2", 9'h122, mtxh)
    apb(1'b1, `I2CFS_ADDR_FSTA, 32'hfffff2ff);
    rd(`I2CFS_ADDR_FSTA, 32'hc8, "mtx_flushed");
    `CHK("mtx_head", 1'b0, mtxh.valid)
    eng(3'h7, 8'h0);
    repeat (3) @(posedge clk);
    rd(`I2CFS_ADDR_FSTA, 32'hc0, "srx_popped");
    `CHK("srx_head2", 1'b0, srxh.valid)
    eng(3'h6, 8'h0);
    eng(3'h3, 8'h66);
    eng(3'h3, 8'h77);
    repeat (3) @(posedge clk);
    rd(`I2CFS_ADDR_FSTA, 32'h8c, "mrx_pop_srx_full");
    `CHK("mrx_head2", 9'h144, mrxh)
    `CHK("srx_head3", 9'h166, srxh)
    rd(`I2CFS_ADDR_IRQ_STAT, 32'h4, "stat_srx");
    apb(1'b0, 32'hffff0958, 32'h0);
    `CHK("unmapped", 1'b1, err)
    $display("test fifo states done");
    final_report();
  end
endmodule
